/* File: design/bcmc_pkg.sv */
// package for the boost converter mode control block
// assumes a single 250 MHz clock domain and an AXI4-Lite register bus
package bcmc_pkg;
    localparam int unsigned BCMC_ADDR_W = 8;
    // register word index is 0xB7, so the byte address is four times it
    localparam logic [7:0] BCMC_CTRL_INDEX = 8'hB7;
    localparam logic [9:0] BCMC_CTRL_ADDR = {BCMC_CTRL_INDEX, 2'h0};
    // own registers: enable and hibernate register bit, status readback
    localparam logic [7:0] BCMC_ENABLE_INDEX = 8'hC0;
    localparam logic [9:0] BCMC_ENABLE_ADDR = {BCMC_ENABLE_INDEX, 2'h0};
    localparam logic [7:0] BCMC_STATUS_INDEX = 8'hC1;
    localparam logic [9:0] BCMC_STATUS_ADDR = {BCMC_STATUS_INDEX, 2'h0};
    // control register fields
    localparam int unsigned BCMC_MODE_BIT = 14;
    localparam int unsigned BCMC_HIB_BEH_BIT = 12;
    localparam int unsigned BCMC_TRIG_LSB = 8;
    localparam int unsigned BCMC_ILIM_BIT = 6;
    localparam int unsigned BCMC_RAMP_LSB = 3;
    localparam int unsigned BCMC_FB_LSB = 0;
    localparam logic [15:0] BCMC_CTRL_WMASK = 16'h535B;
    localparam logic [15:0] BCMC_CTRL_RESET = 16'h0008;
    // enable register fields
    localparam int unsigned BCMC_EN_BIT = 0;
    localparam int unsigned BCMC_HIBREG_BIT = 1;
    // feedback and ramp codes
    localparam logic [1:0] BCMC_FB_EXTERNAL = 2'h0;
    localparam logic [1:0] BCMC_FB_SINK_A = 2'h1;
    localparam logic [1:0] BCMC_FB_RESERVED = 2'h2;
    localparam logic [1:0] BCMC_FB_INTERNAL_5V = 2'h3;
    localparam logic [1:0] BCMC_RAMP_LOW_VOUT = 2'h3;
    localparam logic [1:0] BCMC_RESP_OKAY = 2'h0;
    localparam logic [1:0] BCMC_RESP_SLVERR = 2'h2;
endpackage

/* File: design/bcmc_hib_select.sv */
// hibernate source selection for the boost converter
// assumes low-power and gpio hibernate inputs already synchronous
module bcmc_hib_select
    import bcmc_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // sources
    input wire logic [1:0] hibernate_trigger_select,
    input wire logic hibernate_reg_bit,
    input wire logic [2:0] low_power_in,
    input wire logic gpio_hibernate_in,
    // result
    output logic hibernate_active
);
    // low-power inputs active high; gpio hibernate overrides the selection
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            hibernate_active <= 1'b0;
        end else begin
            unique case (hibernate_trigger_select)
                2'h0: hibernate_active <= hibernate_reg_bit | gpio_hibernate_in;
                2'h1: hibernate_active <= low_power_in[0] | gpio_hibernate_in;
                2'h2: hibernate_active <= low_power_in[1] | gpio_hibernate_in;
                2'h3: hibernate_active <= low_power_in[2] | gpio_hibernate_in;
            endcase
        end
    end
endmodule

/* File: design/bcmc_top.sv */
// boost converter mode control: register file and power stage controls
// assumes an AXI4-Lite master, synchronous inputs, and an analog stage on the outputs
// What this block does
// - in switch mode the pass switch is closed while the enable bit is 1 and open while it is 0 or while hibernate is active with control bit 12 set.
// - control bit 14 selects boost (0) or switch (1) operation and resets to 0.
// - control bits 1:0 select the feedback source, reset 00, with 10 reserved.
// - with feedback 01 the stage regulates so sink A carries the programmed sink current.
// - control bits 4:3 hold the compensation ramp code, reset 01.
// - feedback select 11 forces ramp code 11 regardless of the ramp bits.
// - control bit 6 selects the higher (0) or lower (1) peak current limit, reset 0.
// - control bit 12 keeps the converter running (0) or disables its output (1) in hibernate.
// - control bits 9:8 select the hibernate source: register bit or low-power input one to three.
// - the low-power inputs are active high when selected.
// - an asserted gpio hibernate input forces hibernate regardless of the source selection.
//
// The AXI4-Lite interface to the registers is this design's own decision.
module bcmc_top
    import bcmc_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // axi4-lite write address and data
    input wire logic [9:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read
    input wire logic [9:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // hibernate sources
    input wire logic low_power_input_one,
    input wire logic low_power_input_two,
    input wire logic low_power_input_three,
    input wire logic gpio_hibernate_in,
    // power stage controls
    output logic pass_switch_closed,
    output logic boost_run,
    output logic boost_mode_select,
    output logic [1:0] feedback_source_select,
    output logic [1:0] comp_ramp_code,
    output logic peak_current_limit_select,
    output logic sink_a_regulation
);
    logic [15:0] ctrl;
    logic boost_enable;
    logic hibernate_reg_bit;
    logic hibernate_active;
    logic aw_held;
    logic w_held;
    logic [9:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic next_switch;
    logic next_run;
    logic hib_off;
    logic [31:0] ctrl_merged;

    // the analog stage sees hibernate two cycles after the inputs move
    bcmc_hib_select u_hib (
        .clock(clock),
        .reset_n(reset_n),
        .hibernate_trigger_select(ctrl[BCMC_TRIG_LSB +: 2]),
        .hibernate_reg_bit(hibernate_reg_bit),
        .low_power_in({low_power_input_three, low_power_input_two, low_power_input_one}),
        .gpio_hibernate_in(gpio_hibernate_in),
        .hibernate_active(hibernate_active)
    );

    // merges byte lanes into a register word
    function automatic logic [31:0] bcmc_merge(input logic [31:0] old, input logic [31:0] data,
                                                input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[i*8 +: 8] = data[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // merged word is formed outside the clocked block; the register write keeps only its low half
    assign ctrl_merged = bcmc_merge({16'h0, ctrl}, w_data, w_strb);

    // address and data are latched separately, so either may come first
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            aw_held <= 1'b0;
            aw_addr <= '0;
            s_axi_awready <= 1'b1;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
        end else if (s_axi_bvalid && s_axi_bready) begin
            aw_held <= 1'b0;
            s_axi_awready <= 1'b1;
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            w_held <= 1'b0;
            w_data <= '0;
            w_strb <= '0;
            s_axi_wready <= 1'b1;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
        end else if (s_axi_bvalid && s_axi_bready) begin
            w_held <= 1'b0;
            s_axi_wready <= 1'b1;
        end
    end

    // register write and write response
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            ctrl <= BCMC_CTRL_RESET;
            boost_enable <= 1'b0;
            hibernate_reg_bit <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= BCMC_RESP_OKAY;
        end else if (aw_held && w_held && !s_axi_bvalid) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= BCMC_RESP_OKAY;
            unique case (aw_addr)
                BCMC_CTRL_ADDR: begin
                    ctrl <= ctrl_merged[15:0] & BCMC_CTRL_WMASK;
                end
                BCMC_ENABLE_ADDR: begin
                    if (w_strb[0]) begin
                        boost_enable <= w_data[BCMC_EN_BIT];
                        hibernate_reg_bit <= w_data[BCMC_HIBREG_BIT];
                    end
                end
                default: s_axi_bresp <= BCMC_RESP_SLVERR;
            endcase
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // read channel: one read at a time, answer one cycle after acceptance
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= BCMC_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= BCMC_RESP_OKAY;
            unique case (s_axi_araddr)
                BCMC_CTRL_ADDR: s_axi_rdata <= {16'h0, ctrl};
                BCMC_ENABLE_ADDR: s_axi_rdata <= {30'h0, hibernate_reg_bit, boost_enable};
                BCMC_STATUS_ADDR: s_axi_rdata <= {27'h0, sink_a_regulation, comp_ramp_code,
                                                   boost_run, pass_switch_closed};
                default: begin
                    s_axi_rdata <= '0;
                    s_axi_rresp <= BCMC_RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // output stage controls
    always_comb begin
        hib_off = hibernate_active && ctrl[BCMC_HIB_BEH_BIT];
        next_switch = ctrl[BCMC_MODE_BIT] && boost_enable && !hib_off;
        next_run = !ctrl[BCMC_MODE_BIT] && boost_enable && !hib_off
                   && ctrl[BCMC_FB_LSB +: 2] != BCMC_FB_RESERVED;
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            pass_switch_closed <= 1'b0;
            boost_run <= 1'b0;
            boost_mode_select <= 1'b0;
            feedback_source_select <= BCMC_FB_EXTERNAL;
            comp_ramp_code <= BCMC_CTRL_RESET[BCMC_RAMP_LSB +: 2];
            peak_current_limit_select <= 1'b0;
            sink_a_regulation <= 1'b0;
        end else begin
            pass_switch_closed <= next_switch;
            boost_run <= next_run;
            boost_mode_select <= ctrl[BCMC_MODE_BIT];
            feedback_source_select <= ctrl[BCMC_FB_LSB +: 2];
            // forcing the ramp avoids oscillation on the fixed 5 V rail
            comp_ramp_code <= (ctrl[BCMC_FB_LSB +: 2] == BCMC_FB_INTERNAL_5V) ? BCMC_RAMP_LOW_VOUT
                              : ctrl[BCMC_RAMP_LSB +: 2];
            peak_current_limit_select <= ctrl[BCMC_ILIM_BIT];
            sink_a_regulation <= next_run && ctrl[BCMC_FB_LSB +: 2] == BCMC_FB_SINK_A;
        end
    end

    // stage outputs follow the register one clock late
    a_ramp_forced: assert property (@(posedge clock) disable iff (!reset_n)
        $past(ctrl[1:0]) == 2'h3 |-> comp_ramp_code == 2'h3)
        else $error("ramp not forced for internal divider");
    a_ramp_follows: assert property (@(posedge clock) disable iff (!reset_n)
        $past(ctrl[1:0]) != 2'h3 |-> comp_ramp_code == $past(ctrl[4:3]))
        else $error("ramp code does not follow bits");
    a_switch_close: assert property (@(posedge clock) disable iff (!reset_n)
        pass_switch_closed |-> boost_mode_select && $past(boost_enable))
        else $error("switch closed with enable low");
    a_switch_open: assert property (@(posedge clock) disable iff (!reset_n)
        !$past(boost_enable) |-> !pass_switch_closed && !boost_run)
        else $error("stage active with enable low");
    a_mode_bit: assert property (@(posedge clock) disable iff (!reset_n)
        boost_mode_select == $past(ctrl[14]) && (!boost_run || !boost_mode_select))
        else $error("mode select mismatch");
    a_mode_excl: assert property (@(posedge clock) disable iff (!reset_n)
        boost_mode_select |-> !boost_run && !sink_a_regulation)
        else $error("boost active in switch mode");
    a_fb_source: assert property (@(posedge clock) disable iff (!reset_n)
        feedback_source_select == $past(ctrl[1:0]) && (!boost_run || feedback_source_select != 2'h2))
        else $error("feedback source mismatch");
    a_reserved_stop: assert property (@(posedge clock) disable iff (!reset_n)
        $past(ctrl[1:0]) == 2'h2 |-> !boost_run && !sink_a_regulation)
        else $error("boost running on reserved feedback");
    a_sink_reg: assert property (@(posedge clock) disable iff (!reset_n)
        sink_a_regulation |-> boost_run && feedback_source_select == 2'h1)
        else $error("sink regulation outside sink feedback");
    a_sink_follow: assert property (@(posedge clock) disable iff (!reset_n)
        $past(ctrl[1:0]) == 2'h1 && $past(boost_enable) && !$past(ctrl[14]) && !$past(ctrl[12]) |-> sink_a_regulation)
        else $error("sink regulation missing");
    a_ilim_bit: assert property (@(posedge clock) disable iff (!reset_n)
        peak_current_limit_select == $past(ctrl[6]))
        else $error("current limit mismatch");

    // hibernate source and behaviour
    a_hib_disable: assert property (@(posedge clock) disable iff (!reset_n)
        $past(hibernate_active) && $past(ctrl[12]) |-> !pass_switch_closed && !boost_run)
        else $error("output on in disabling hibernate");
    a_hib_keep: assert property (@(posedge clock) disable iff (!reset_n)
        !$past(ctrl[12]) && $past(boost_enable) && !$past(ctrl[14]) && $past(ctrl[1:0]) != 2'h2 |-> boost_run)
        else $error("boost stopped although hibernate keeps it running");
    a_switch_keep: assert property (@(posedge clock) disable iff (!reset_n)
        !$past(ctrl[12]) && $past(boost_enable) && $past(ctrl[14]) |-> pass_switch_closed)
        else $error("switch open with enable high");
    a_gpio_hib: assert property (@(posedge clock) disable iff (!reset_n)
        gpio_hibernate_in |=> hibernate_active)
        else $error("gpio hibernate ignored");
    a_trig_reg: assert property (@(posedge clock) disable iff (!reset_n)
        ctrl[9:8] == 2'h0 && hibernate_reg_bit |=> hibernate_active)
        else $error("hibernate register bit ignored");
    a_lp_one: assert property (@(posedge clock) disable iff (!reset_n)
        ctrl[9:8] == 2'h1 && low_power_input_one |=> hibernate_active)
        else $error("low-power input one ignored");
    a_lp_select: assert property (@(posedge clock) disable iff (!reset_n)
        ctrl[9:8] == 2'h2 && low_power_input_two |=> hibernate_active)
        else $error("low-power input two ignored");
    a_lp_three: assert property (@(posedge clock) disable iff (!reset_n)
        ctrl[9:8] == 2'h3 && low_power_input_three |=> hibernate_active)
        else $error("low-power input three ignored");
    a_lp_idle: assert property (@(posedge clock) disable iff (!reset_n)
        ctrl[9:8] == 2'h1 && !low_power_input_one && !gpio_hibernate_in |=> !hibernate_active)
        else $error("hibernate with selected input low");

    // bus answers stand until taken and never overlap a new request
    a_write_answer: assert property (@(posedge clock) disable iff (!reset_n)
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write accepted while response pending");
    a_write_once: assert property (@(posedge clock) disable iff (!reset_n)
        s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response repeated");
    a_read_answer: assert property (@(posedge clock) disable iff (!reset_n)
        s_axi_rvalid |-> !s_axi_arready)
        else $error("read accepted while data pending");
    a_read_once: assert property (@(posedge clock) disable iff (!reset_n)
        s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
        else $error("read data repeated");
    a_rdata_slverr: assert property (@(posedge clock) disable iff (!reset_n)
        s_axi_rvalid && s_axi_rresp == BCMC_RESP_SLVERR |-> s_axi_rdata == 32'h0)
        else $error("data returned on refused read");
    a_ctrl_mask: assert property (@(posedge clock) disable iff (!reset_n)
        (ctrl & ~BCMC_CTRL_WMASK) == 16'h0)
        else $error("reserved control bits set");
    c_lp_hib: cover property (@(posedge clock) disable iff (!reset_n) hibernate_active && ctrl[9:8] != 2'h0);
    c_switch_on: cover property (@(posedge clock) disable iff (!reset_n) pass_switch_closed);
    c_boost_sink: cover property (@(posedge clock) disable iff (!reset_n) sink_a_regulation);
    c_hib_off: cover property (@(posedge clock) disable iff (!reset_n) hibernate_active && ctrl[12] && boost_enable);
    c_ramp_forced: cover property (@(posedge clock) disable iff (!reset_n) boost_run && comp_ramp_code == 2'h3);
endmodule

/* File: verification/bcmc_stage_model.sv */
// boost power stage, inductor and led string as seen from the control outputs
// assumes the controls come registered from the block's clock domain
module bcmc_stage_model
    import bcmc_pkg::*;
(
    // controls
    input wire logic pass_switch_closed,
    input wire logic boost_run,
    input wire logic [1:0] feedback_source_select,
    input wire logic [1:0] comp_ramp_code,
    // stage state
    output logic [1:0] stage_state,
    output logic sub_harmonic_risk
);
    timeunit 1ns;
    timeprecision 1ps;
    // 1 = pass switch, 2 = boosting, 0 = off; switch wins so a double drive never looks like boost
    assign stage_state = pass_switch_closed ? 2'h1 : (boost_run ? 2'h2 : 2'h0);
    // the fixed 5 V output rings unless the lowest ramp is in use
    assign sub_harmonic_risk = boost_run && feedback_source_select == BCMC_FB_INTERNAL_5V
        && comp_ramp_code != BCMC_RAMP_LOW_VOUT;
endmodule

/* File: verification/boost_converter_mode_control_tb_top.sv */
// self-checking bench: register bus tasks, a row table of settings, then bus corner cases and a mid-run reset
// assumes the hibernate inputs are synchronous and the gpio pins already set up as low-power inputs
module boost_converter_mode_control_tb_top
    import bcmc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {logic [15:0] ctrl; logic [1:0] en; logic [2:0] lp; logic gpio; logic [8:0] exp;} bcmc_row_s;
    logic clock, reset_n, awvalid, wvalid, bready, arvalid, rready, gpio;
    logic [9:0] awaddr, araddr;
    logic [31:0] wdata, data;
    logic [3:0] wstrb;
    logic [2:0] lp;
    logic [1:0] resp, stage_state;
    logic risk, awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    wire [8:0] stage_out;
    int mismatches = 0;
    int tests_run = 0;
    int cycles = 0;
    // {pass switch, run, mode, feedback, ramp, current limit, sink regulation}
    bcmc_row_s rows [16] = '{
        '{16'h0008, 2'h1, 3'h0, 1'b0, 9'h084}, '{16'h0001, 2'h1, 3'h0, 1'b0, 9'h091},
        '{16'h0013, 2'h1, 3'h0, 1'b0, 9'h0BC}, '{16'h0002, 2'h1, 3'h0, 1'b0, 9'h020},
        '{16'h4040, 2'h1, 3'h0, 1'b0, 9'h142}, '{16'h4000, 2'h0, 3'h0, 1'b0, 9'h040},
        '{16'h5000, 2'h3, 3'h0, 1'b0, 9'h040}, '{16'h4000, 2'h3, 3'h0, 1'b0, 9'h140},
        '{16'h5100, 2'h1, 3'h1, 1'b0, 9'h040}, '{16'h5100, 2'h1, 3'h6, 1'b0, 9'h140},
        '{16'h5200, 2'h1, 3'h2, 1'b0, 9'h040}, '{16'h5300, 2'h1, 3'h4, 1'b0, 9'h040},
        '{16'h5300, 2'h1, 3'h3, 1'b0, 9'h140}, '{16'h5000, 2'h1, 3'h0, 1'b1, 9'h040},
        '{16'h5300, 2'h1, 3'h0, 1'b1, 9'h040}, '{16'h1008, 2'h3, 3'h0, 1'b0, 9'h004}};
    bcmc_top bcmc_top_i (.clock(clock), .reset_n(reset_n),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .low_power_input_one(lp[0]), .low_power_input_two(lp[1]), .low_power_input_three(lp[2]),
        .gpio_hibernate_in(gpio), .pass_switch_closed(stage_out[8]), .boost_run(stage_out[7]),
        .boost_mode_select(stage_out[6]), .feedback_source_select(stage_out[5:4]),
        .comp_ramp_code(stage_out[3:2]), .peak_current_limit_select(stage_out[1]),
        .sink_a_regulation(stage_out[0]));
    bcmc_stage_model bcmc_stage_model_i (.pass_switch_closed(stage_out[8]), .boost_run(stage_out[7]),
        .feedback_source_select(stage_out[5:4]), .comp_ramp_code(stage_out[3:2]),
        .stage_state(stage_state), .sub_harmonic_risk(risk));
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // master waits on the slave's own answer; only the cycle ceiling ends a hang
    task automatic bus_write(input logic [9:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
        @(posedge clock);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        forever begin
            @(posedge clock);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        r = bresp;
        bready <= 1'b0;
    endtask
    task automatic bus_read(input logic [9:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge clock);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        forever begin
            @(posedge clock);
            if (arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end
    always @(posedge clock) begin
        cycles++;
        if (cycles == 5000) begin
            mismatches++;
            conclude();
        end
    end
    initial begin
        reset_n = 1'b0;
        {awaddr, awvalid, wdata, wstrb, wvalid, bready, araddr, arvalid, rready, lp, gpio} = '0;
        repeat (16) @(posedge clock);
        reset_n <= 1'b1;
        // ramp codes in the rows are taken as matching the intended output
        // gpio pins are taken as already set up for low-power input duty
        foreach (rows[i]) begin
            lp <= rows[i].lp;
            gpio <= rows[i].gpio;
            bus_write(BCMC_ENABLE_ADDR, {30'h0, rows[i].en}, 4'hF, resp);
            bus_write(BCMC_CTRL_ADDR, {16'h0, rows[i].ctrl}, 4'hF, resp);
            check({30'h0, resp}, {30'h0, BCMC_RESP_OKAY});
            bus_read(BCMC_CTRL_ADDR, data, resp);
            check(data, {16'h0, rows[i].ctrl});
            repeat (4) @(posedge clock);
            check({23'h0, stage_out}, {23'h0, rows[i].exp});
            check({31'h0, risk}, 32'h0);
            check({30'h0, stage_state}, {30'h0, rows[i].exp[7] & ~rows[i].exp[8], rows[i].exp[8]});
            bus_read(BCMC_STATUS_ADDR, data, resp);
            check(data, {27'h0, rows[i].exp[0], rows[i].exp[3:2], rows[i].exp[7], rows[i].exp[8]});
        end
        // reserved bits read back as zero, masked lanes stay untouched
        bus_write(BCMC_CTRL_ADDR, 32'hFFFFFFFF, 4'hF, resp);
        bus_read(BCMC_CTRL_ADDR, data, resp);
        check(data, 32'h0000535B);
        bus_write(BCMC_CTRL_ADDR, 32'h0, 4'h2, resp);
        bus_read(BCMC_CTRL_ADDR, data, resp);
        check(data, 32'h0000005B);
        bus_write(10'h3FC, 32'hFFFFFFFF, 4'hF, resp);
        check({30'h0, resp}, {30'h0, BCMC_RESP_SLVERR});
        bus_write(BCMC_STATUS_ADDR, 32'hFFFFFFFF, 4'hF, resp);
        check({30'h0, resp}, {30'h0, BCMC_RESP_SLVERR});
        bus_read(10'h3FC, data, resp);
        check({data[29:0], resp}, {30'h0, BCMC_RESP_SLVERR});
        // second reset in mid-run brings every field back to its default
        @(posedge clock);
        reset_n <= 1'b0;
        repeat (2) @(posedge clock);
        check({23'h0, stage_out}, 32'h00000004);
        reset_n <= 1'b1;
        bus_read(BCMC_CTRL_ADDR, data, resp);
        check(data, {16'h0, BCMC_CTRL_RESET});
        bus_read(BCMC_ENABLE_ADDR, data, resp);
        check(data, 32'h0);
        conclude();
    end
endmodule
